/* cvr_status_regs.sv */
// processor status word, stack pointer, operand registers, dual data pointer
// Summary of operation
// - stack pointer increments before push
// - stack pointer resets to 07H
// - stack reaches anywhere in 256-byte internal memory
// - carry set on carry or borrow
// - half carry set on nibble carry/borrow
// - carry doubles as boolean accumulator
// - bank bits select one of four banks
// - add/subtract signed overflow sets wrap flag
// - multiply product above 255 sets wrap flag
// - divide by zero sets wrap flag
// - those ops clear wrap flag otherwise
// - parity shows odd ones in main operand
// - status word bit layout at D0H
// - two user flags are plain software bits
// - second operand serves multiply and divide
// - data pointer is 16 bits, two bytes
// - two pointers, select bit at A2H
// - select 0 first pointer, 1 second
// - aux register resets to xxxx,0xx0 with soft flag
// - incrementing aux register toggles pointer select
`timescale 1ns/1ps
`default_nettype none
`include "cvr_defines.svh"

module cvr_status_regs
  import cvr_pkg::*;
(
  input  wire logic        clk,              // 20 MHz core clock
  input  wire logic        srst,             // synchronous reset, high
  input  wire cvr_sfr_t    sfr,              // register access
  output logic      [7:0]  sfr_rdata,        // read data, one cycle after rd
  input  wire cvr_cmd_t    cmd,              // core operation
  output logic      [7:0]  stack_pointer,    // current stack pointer
  output logic      [7:0]  push_addr,        // where the pushed byte goes
  output logic      [4:0]  bank_base,        // base address of R0
  output logic      [15:0] data_pointer,     // selected pointer
  output logic      [7:0]  main_operand_reg, // accumulator
  output logic      [7:0]  status_word       // status word as read
);

  // ==================== state
  logic [7:0]  second_operand_reg;  // multiply/divide helper
  logic        carry_flag;          // carry, boolean accumulator
  logic        half_carry_flag;     // nibble carry
  logic        user_flag_zero;      // software flag
  logic        bank_select_high;    // bank bit 1
  logic        bank_select_low;     // bank bit 0
  logic        signed_wrap_flag;    // overflow
  logic        user_flag_one;       // software flag
  logic        pointer_select;      // 0 first, 1 second pointer
  logic        general_soft_flag;   // software flag in aux reg
  logic [15:0] data_pointer_q [2];          // both data pointers

  // ==================== decode
  wire       wr_sp   = sfr.wr && (sfr.addr == `CVR_ADDR_SP);
  wire       wr_dpl  = sfr.wr && (sfr.addr == `CVR_ADDR_DPL);
  wire       wr_dph  = sfr.wr && (sfr.addr == `CVR_ADDR_DPH);
  wire       wr_aux  = sfr.wr && (sfr.addr == `CVR_ADDR_AUX);
  wire       wr_psw  = sfr.wr && (sfr.addr == `CVR_ADDR_PSW);
  wire       wr_acc  = sfr.wr && (sfr.addr == `CVR_ADDR_ACC);
  wire       wr_b    = sfr.wr && (sfr.addr == `CVR_ADDR_B);
  // a register write wins over a core operation in the same cycle
  wire       go      = cmd.valid && !sfr.wr;
  wire       op_add  = go && (cmd.op == cvr_op_add);
  wire       op_addc = go && (cmd.op == cvr_op_addc);
  wire       op_subb = go && (cmd.op == cvr_op_subb);
  wire       op_mul  = go && (cmd.op == cvr_op_mul);
  wire       op_div  = go && (cmd.op == cvr_op_div);
  wire       op_push = go && (cmd.op == cvr_op_push);
  wire       op_pop  = go && (cmd.op == cvr_op_pop);
  wire       op_cwr  = go && (cmd.op == cvr_op_carry_wr);
  wire       op_ainc = go && (cmd.op == cvr_op_aux_inc);
  wire       op_dinc = go && (cmd.op == cvr_op_data_pointer_inc);
  wire       op_dld  = go && (cmd.op == cvr_op_data_pointer_load);
  wire [7:0] opnd    = cmd.operand[7:0];

  // ==================== arithmetic
  // carry in only for the with-carry forms
  wire       cin     = (op_addc || op_subb) && carry_flag;
  wire [8:0] sum9    = {1'b0, main_operand_reg} + {1'b0, opnd} + {8'h00, cin};
  wire [4:0] sum5    = {1'b0, main_operand_reg[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire [8:0] dif9    = {1'b0, main_operand_reg} - {1'b0, opnd} - {8'h00, cin};
  wire [4:0] dif5    = {1'b0, main_operand_reg[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
  // signed overflow: add of like signs or subtract of unlike signs, result takes the other sign
  wire       add_ov  = (main_operand_reg[7] == opnd[7]) && (sum9[7] != opnd[7]);
  wire       sub_ov  = (main_operand_reg[7] != opnd[7]) && (dif9[7] != main_operand_reg[7]);
  wire [15:0] prod   = {8'h00, main_operand_reg} * {8'h00, second_operand_reg};
  wire       div_zero = (second_operand_reg == `CVR_ZERO_BYTE);
  wire [7:0] quo     = div_zero ? main_operand_reg : main_operand_reg / second_operand_reg;
  wire [7:0] rem     = div_zero ? second_operand_reg : main_operand_reg % second_operand_reg;

  // ==================== next values
  logic [7:0] next_acc;       // accumulator
  logic [7:0] next_b;         // second operand
  logic [7:0] next_sp;        // stack pointer
  logic       next_cy;        // carry
  logic       next_ac;        // half carry
  logic       next_ov;        // overflow
  logic       next_dps;       // pointer select

  // accumulator and second operand
  always_comb begin
    next_acc = main_operand_reg;
    next_b   = second_operand_reg;
    if (wr_acc) begin
      next_acc = sfr.wdata;
    end else if (op_add || op_addc) begin
      next_acc = sum9[7:0];
    end else if (op_subb) begin
      next_acc = dif9[7:0];
    end else if (op_mul) begin
      next_acc = prod[7:0];
      next_b   = prod[15:8];
    end else if (op_div) begin
      next_acc = quo;
      next_b   = rem;
    end
    if (wr_b) begin
      next_b = sfr.wdata;
    end
  end

  // stack pointer: 8 bits, wraps inside 256 bytes
  always_comb begin
    next_sp = stack_pointer;
    if (wr_sp) begin
      next_sp = sfr.wdata;
    end else if (op_push) begin
      next_sp = stack_pointer + `CVR_ONE_BYTE;
    end else if (op_pop) begin
      next_sp = stack_pointer - `CVR_ONE_BYTE;
    end
  end

  // carry, half carry and overflow
  always_comb begin
    next_cy = carry_flag;
    next_ac = half_carry_flag;
    next_ov = signed_wrap_flag;
    if (wr_psw) begin
      next_cy = sfr.wdata[`CVR_PSW_CY];
      next_ac = sfr.wdata[`CVR_PSW_AC];
      next_ov = sfr.wdata[`CVR_PSW_OV];
    end else if (op_add || op_addc) begin
      next_cy = sum9[8];
      next_ac = sum5[4];
      next_ov = add_ov;
    end else if (op_subb) begin
      next_cy = dif9[8];
      next_ac = dif5[4];
      next_ov = sub_ov;
    end else if (op_mul || op_div) begin
      next_cy = 1'b0;
      next_ac = 1'b0;
      next_ov = op_mul ? (prod > `CVR_BYTE_MAX) : div_zero;
    end else if (op_cwr) begin
      next_cy = opnd[0];
    end
  end

  // pointer select: written, or toggled by an increment
  always_comb begin
    next_dps = pointer_select;
    if (wr_aux) begin
      next_dps = sfr.wdata[`CVR_AUX_DPS];
    end else if (op_ainc) begin
      next_dps = !pointer_select;
    end
  end

  // ==================== registers
  // operand registers and stack pointer
  always_ff @(posedge clk) begin
    if (srst) begin
      main_operand_reg   <= `CVR_RST_BYTE;
      second_operand_reg <= `CVR_RST_BYTE;
      stack_pointer      <= `CVR_RST_SP;
    end else begin
      main_operand_reg   <= next_acc;
      second_operand_reg <= next_b;
      stack_pointer      <= next_sp;
    end
  end

  // status word flags
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_flag       <= 1'b0;
      half_carry_flag  <= 1'b0;
      signed_wrap_flag <= 1'b0;
    end else begin
      carry_flag       <= next_cy;
      half_carry_flag  <= next_ac;
      signed_wrap_flag <= next_ov;
    end
  end

  // software-owned status bits
  always_ff @(posedge clk) begin
    if (srst) begin
      user_flag_zero   <= 1'b0;
      user_flag_one    <= 1'b0;
      bank_select_high <= 1'b0;
      bank_select_low  <= 1'b0;
    end else if (wr_psw) begin
      user_flag_zero   <= sfr.wdata[`CVR_PSW_F0];
      user_flag_one    <= sfr.wdata[`CVR_PSW_F1];
      bank_select_high <= sfr.wdata[`CVR_PSW_RS1];
      bank_select_low  <= sfr.wdata[`CVR_PSW_RS0];
    end
  end

  // aux select register
  always_ff @(posedge clk) begin
    if (srst) begin
      pointer_select    <= 1'b0;
      general_soft_flag <= 1'b0;
    end else begin
      pointer_select    <= next_dps;
      if (wr_aux) begin
        general_soft_flag <= sfr.wdata[`CVR_AUX_GF];
      end
    end
  end

  // ==================== dual data pointer
  // only the selected pointer changes; the other holds
  generate
    for (genvar i = 0; i < 2; i++) begin : g_data_pointer
      wire sel = (pointer_select == 1'(i));
      always_ff @(posedge clk) begin
        if (srst) begin
          data_pointer_q[i] <= `CVR_RST_DATA_POINTER;
        end else if (sel) begin
          if (wr_dpl) begin
            data_pointer_q[i][7:0] <= sfr.wdata;
          end else if (wr_dph) begin
            data_pointer_q[i][15:8] <= sfr.wdata;
          end else if (op_dld) begin
            data_pointer_q[i] <= cmd.operand;
          end else if (op_dinc) begin
            data_pointer_q[i] <= data_pointer_q[i] + `CVR_ONE_WORD;
          end
        end
      end
    end
  endgenerate

  // ==================== outputs
  assign data_pointer = data_pointer_q[pointer_select];
  assign push_addr    = stack_pointer;
  assign bank_base    = {bank_select_high, bank_select_low, 3'b000};
  // parity follows the accumulator without delay
  assign status_word  = {carry_flag, half_carry_flag, user_flag_zero,
                         bank_select_high, bank_select_low, signed_wrap_flag,
                         user_flag_one, ^main_operand_reg};

  // read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr.addr)
      `CVR_ADDR_SP:  rd_mux = stack_pointer;
      `CVR_ADDR_DPL: rd_mux = data_pointer[7:0];
      `CVR_ADDR_DPH: rd_mux = data_pointer[15:8];
      `CVR_ADDR_AUX: rd_mux = {4'h0, general_soft_flag, 2'b00, pointer_select};
      `CVR_ADDR_PSW: rd_mux = status_word;
      `CVR_ADDR_ACC: rd_mux = main_operand_reg;
      `CVR_ADDR_B:   rd_mux = second_operand_reg;
      default:       rd_mux = `CVR_ZERO_BYTE;
    endcase
  end

  // read data register
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= `CVR_ZERO_BYTE;
    end else if (sfr.rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // ==================== checks
  property p_sp_reset;
    @(posedge clk) $fell(srst) |-> stack_pointer == `CVR_RST_SP;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("stack pointer not 07H after reset");

  property p_push;
    @(posedge clk) disable iff (srst)
      op_push |=> (stack_pointer == $past(stack_pointer) + 8'h01) && push_addr == stack_pointer;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not pre-increment");

  property p_add_carry;
    @(posedge clk) disable iff (srst)
      (op_add && main_operand_reg == 8'hFF && opnd == 8'h01) |=>
        carry_flag && half_carry_flag && main_operand_reg == 8'h00;
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry or half carry wrong");

  property p_sub_borrow;
    @(posedge clk) disable iff (srst)
      (op_subb && !carry_flag && main_operand_reg == 8'h10 && opnd == 8'h01) |=>
        !carry_flag && half_carry_flag && main_operand_reg == 8'h0F;
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract nibble borrow wrong");

  property p_add_ov;
    @(posedge clk) disable iff (srst)
      (op_add && main_operand_reg == 8'h7F && opnd == 8'h01) |=> signed_wrap_flag;
  endproperty
  a_add_ov: assert property (p_add_ov)
    else $error("signed overflow missed");

  property p_mul_ov;
    @(posedge clk) disable iff (srst)
      op_mul |=> signed_wrap_flag == (second_operand_reg != 8'h00) && !carry_flag;
  endproperty
  a_mul_ov: assert property (p_mul_ov)
    else $error("multiply overflow wrong");

  property p_div_zero;
    @(posedge clk) disable iff (srst)
      (op_div && div_zero) |=> signed_wrap_flag && $stable(main_operand_reg);
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("divide by zero not flagged");

  property p_parity;
    @(posedge clk) disable iff (srst)
      wr_acc |=> status_word[0] == ^$past(sfr.wdata);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity does not follow accumulator");

  property p_bank;
    @(posedge clk) disable iff (srst)
      wr_psw |=> bank_base == {$past(sfr.wdata[`CVR_PSW_RS1:`CVR_PSW_RS0]), 3'b000};
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank base wrong");

  property p_toggle;
    @(posedge clk) disable iff (srst)
      op_ainc |=> pointer_select != $past(pointer_select);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pointer select did not toggle");

  property p_hold;
    @(posedge clk) disable iff (srst)
      (op_dld && !pointer_select) |=>
        data_pointer_q[1] == $past(data_pointer_q[1]) && data_pointer == $past(cmd.operand);
  endproperty
  a_hold: assert property (p_hold)
    else $error("unselected pointer changed");

endmodule // cvr_status_regs
`default_nettype wire

/* cvr_defines.svh */
// constants of the processor status and pointer registers
`ifndef CVR_DEFINES_SVH
`define CVR_DEFINES_SVH
// ==================== register addresses
`define CVR_ADDR_SP    8'h81
`define CVR_ADDR_DPL   8'h82
`define CVR_ADDR_DPH   8'h83
`define CVR_ADDR_AUX   8'hA2
`define CVR_ADDR_PSW   8'hD0
`define CVR_ADDR_ACC   8'hE0
`define CVR_ADDR_B     8'hF0
// ==================== reset values
`define CVR_RST_SP     8'h07
`define CVR_RST_BYTE   8'h00
`define CVR_RST_DATA_POINTER   16'h0000
// ==================== status word bit positions
`define CVR_PSW_CY     7
`define CVR_PSW_AC     6
`define CVR_PSW_F0     5
`define CVR_PSW_RS1    4
`define CVR_PSW_RS0    3
`define CVR_PSW_OV     2
`define CVR_PSW_F1     1
`define CVR_PSW_P      0
// ==================== aux select bit positions
`define CVR_AUX_GF     3
`define CVR_AUX_DPS    0
// ==================== misc
`define CVR_BYTE_MAX   16'h00FF
`define CVR_ZERO_BYTE  8'h00
`define CVR_ONE_BYTE   8'h01
`define CVR_ONE_WORD   16'h0001
`endif

/* cvr_pkg.sv */
// types shared by the processor status and pointer registers
package cvr_pkg;
  // operations that the core hands to the register block
  typedef enum logic [3:0] {
    cvr_op_none, cvr_op_add, cvr_op_addc, cvr_op_subb, cvr_op_mul, cvr_op_div,
    cvr_op_push, cvr_op_pop, cvr_op_carry_wr, cvr_op_aux_inc,
    cvr_op_data_pointer_inc, cvr_op_data_pointer_load
  } cvr_op_t;
  // one command from the core
  typedef struct packed {
    logic        valid;
    cvr_op_t     op;
    logic [15:0] operand;
  } cvr_cmd_t;
  // special function register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvr_sfr_t;
endpackage

/* tb_cvr_status_regs.sv */
// self-checking bench for the status word, stack pointer and dual data pointer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import cvr_pkg::*;
  // ==================== design signals
  logic        clk;              // 20 MHz core clock
  logic        srst;             // synchronous reset, high
  cvr_sfr_t    sfr;              // register access
  cvr_cmd_t    cmd;              // core operation
  logic [7:0]  sfr_rdata;        // read data
  logic [7:0]  stack_pointer;    // stack pointer
  logic [7:0]  push_addr;        // push target
  logic [4:0]  bank_base;        // base of R0
  logic [15:0] data_pointer;     // selected pointer
  logic [7:0]  main_operand_reg; // accumulator
  logic [7:0]  status_word;      // status word
  // ==================== model state and bookkeeping
  int          m_sp, m_acc, m_b, m_cy, m_ac, m_f0, m_rs, m_ov, m_f1, m_dps, m_gf, m_rd;
  int          m_dp [2];         // both pointers
  int          n_mismatch;       // mismatches seen
  int          samples_checked;  // comparisons made
  int          cycles = 0;       // hang guard
  integer      seed;             // random seed
  logic [7:0]  addrs [9] = '{8'h81, 8'h82, 8'h83, 8'hA2, 8'hD0, 8'hE0, 8'hF0, 8'h55, 8'h00};
  int          ar_a [7] = '{8'h7F, 8'hFF, 8'h0F, 8'h00, 8'h80, 8'h55, 8'h10}; // arithmetic operands
  int          ar_b [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'hAA, 8'h01};
  cvr_op_t     arith [3] = '{cvr_op_add, cvr_op_addc, cvr_op_subb};
  int          md_a [5] = '{8'h10, 8'h0F, 8'h07, 8'h09, 8'hFF}; // multiply/divide cases
  int          md_b [5] = '{8'h10, 8'h02, 8'h02, 8'h00, 8'h01};
  cvr_op_t     md_op [5] = '{cvr_op_mul, cvr_op_mul, cvr_op_div, cvr_op_div, cvr_op_div};

  // ==================== device under test
  cvr_status_regs dut (
    .clk              (clk),
    .srst             (srst),
    .sfr              (sfr),
    .sfr_rdata        (sfr_rdata),
    .cmd              (cmd),
    .stack_pointer    (stack_pointer),
    .push_addr        (push_addr),
    .bank_base        (bank_base),
    .data_pointer     (data_pointer),
    .main_operand_reg (main_operand_reg),
    .status_word      (status_word)
  );

  // ==================== clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cut a hang short well past the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==================== behavioural model
  function automatic int m_psw();
    return (m_cy << 7) | (m_ac << 6) | (m_f0 << 5) | (m_rs << 3) | (m_ov << 2) | (m_f1 << 1)
           | ($countones(m_acc) % 2);
  endfunction
  // state after reset
  function automatic void m_reset();
    {m_acc, m_b, m_cy, m_ac, m_f0, m_rs, m_ov, m_f1, m_dps, m_gf, m_rd} = '0;
    m_sp = 8'h07;
    m_dp = '{0, 0};
  endfunction
  // register read, unmapped gives zero
  function automatic int m_read(input int a);
    case (a)
      8'h81:   return m_sp;
      8'h82:   return m_dp[m_dps] & 8'hFF;
      8'h83:   return m_dp[m_dps] >> 8;
      8'hA2:   return (m_gf << 3) | m_dps;
      8'hD0:   return m_psw();
      8'hE0:   return m_acc;
      8'hF0:   return m_b;
      default: return 0;
    endcase
  endfunction
  // register write, parity bit not writable
  function automatic void m_write(input int a, input int d);
    case (a)
      8'h81: m_sp = d;
      8'h82: m_dp[m_dps] = (m_dp[m_dps] & 16'hFF00) | d;
      8'h83: m_dp[m_dps] = (m_dp[m_dps] & 16'h00FF) | (d << 8);
      8'hA2: begin
        m_gf  = d[3];
        m_dps = d[0];
      end
      8'hD0: begin
        m_cy = d[7];
        m_ac = d[6];
        m_f0 = d[5];
        m_rs = d[4:3];
        m_ov = d[2];
        m_f1 = d[1];
      end
      8'hE0: m_acc = d;
      8'hF0: m_b = d;
      default: ;
    endcase
  endfunction
  // core operations
  function automatic void m_op(input cvr_op_t o, input int v);
    int a, c, r;
    a = v & 8'hFF;
    c = (o == cvr_op_add) ? 0 : m_cy;
    case (o)
      cvr_op_add, cvr_op_addc: begin
        r = m_acc + a + c;
        m_ac = ((m_acc & 8'h0F) + (a & 8'h0F) + c) > 8'h0F;
        m_ov = ((m_acc ^ r) & (a ^ r) & 8'h80) != 0;
        m_cy = r > 8'hFF;
        m_acc = r & 8'hFF;
      end
      cvr_op_subb: begin
        r = m_acc - a - c;
        m_ac = (m_acc & 8'h0F) < ((a & 8'h0F) + c);
        m_ov = ((m_acc ^ a) & (m_acc ^ r) & 8'h80) != 0;
        m_cy = r < 0;
        m_acc = r & 8'hFF;
      end
      cvr_op_mul: begin
        r = m_acc * m_b;
        m_acc = r & 8'hFF;
        m_b = r >> 8;
        m_cy = 0;
        m_ac = 0;
        m_ov = m_b != 0;
      end
      cvr_op_div: begin
        m_cy = 0;
        m_ac = 0;
        m_ov = m_b == 0;
        if (m_b != 0) begin
          r = m_acc / m_b;
          m_b = m_acc % m_b;
          m_acc = r;
        end
      end
      cvr_op_push:      m_sp = (m_sp + 1) & 8'hFF;
      cvr_op_pop:       m_sp = (m_sp - 1) & 8'hFF;
      cvr_op_carry_wr:  m_cy = v & 1;
      cvr_op_aux_inc:   m_dps ^= 1;
      cvr_op_data_pointer_inc:  m_dp[m_dps] = (m_dp[m_dps] + 1) & 16'hFFFF;
      cvr_op_data_pointer_load: m_dp[m_dps] = v & 16'hFFFF;
      default: ;
    endcase
  endfunction

  // ==================== compare and drive tasks
  task automatic cmp(input string nm, input int exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp[15:0]) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp[15:0], got);
    end
  endtask
  // every state output but sfr_rdata against the model
  task automatic check_all();
    cmp("stack_pointer", m_sp, {8'h00, stack_pointer});
    cmp("push_addr", m_sp, {8'h00, push_addr});
    cmp("bank_base", m_rs * 8, {11'h000, bank_base});
    cmp("data_pointer", m_dp[m_dps], data_pointer);
    cmp("main_operand_reg", m_acc, {8'h00, main_operand_reg});
    cmp("status_word", m_psw(), {8'h00, status_word});
  endtask
  // one cycle: drive, let the edge land, update model, compare
  task automatic step(input cvr_cmd_t c, input cvr_sfr_t s);
    int exp_rd;
    cmd = c;
    sfr = s;
    exp_rd = m_read(s.addr);
    @(posedge clk);
    #1;
    if (s.wr) m_write(s.addr, s.wdata);
    else if (c.valid) m_op(c.op, c.operand);
    // read data is taken on a read and holds until the next one
    if (s.rd) m_rd = exp_rd;
    check_all();
    cmp("sfr_rdata", m_rd, {8'h00, sfr_rdata});
  endtask
  task automatic do_op(input cvr_op_t o, input int v);
    cvr_cmd_t c;
    c = {1'b1, o, v[15:0]};
    step(c, '0);
  endtask
  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    step('0, {1'b1, 1'b0, a, d});
  endtask
  task automatic do_rd(input logic [7:0] a);
    step('0, {1'b0, 1'b1, a, 8'h00});
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==================== main sequence
  initial begin
    int i, k, r;
    cvr_cmd_t c;
    cvr_sfr_t s;
    seed = 32'h8282AF2A;
    {n_mismatch, samples_checked} = '0;
    srst = 1'b1;
    sfr = '0;
    cmd = '0;
    m_reset();
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    check_all();
    foreach (addrs[j]) do_rd(addrs[j]);
    // push from reset lands in bank 1, then wrap at the top
    do_op(cvr_op_push, 0);
    do_op(cvr_op_pop, 0);
    do_wr(8'h81, 8'hFE);
    repeat (2) do_op(cvr_op_push, 0);
    // bank select and user flags, parity bit not writable
    for (i = 0; i < 4; i++) begin
      do_wr(8'hD0, 8'(i * 8) | 8'h22);
      do_rd(8'hD0);
    end
    do_wr(8'hD0, 8'hFF);
    // add, add with carry, subtract with borrow at boundary operands
    for (i = 0; i < 7; i++) begin
      for (k = 0; k < 3; k++) begin
        do_op(cvr_op_carry_wr, i + k);
        do_wr(8'hE0, 8'(ar_a[i]));
        do_op(arith[k], ar_b[i]);
      end
    end
    // multiply and divide, carry and wrap preset so clearing shows
    for (i = 0; i < 5; i++) begin
      do_wr(8'hD0, 8'hC4);
      do_wr(8'hE0, 8'(md_a[i]));
      do_wr(8'hF0, 8'(md_b[i]));
      do_op(md_op[i], 0);
      do_rd(8'hF0);
    end
    // dual pointer: load both, toggle, byte access, wrap
    do_wr(8'hA2, 8'h00);
    do_op(cvr_op_data_pointer_load, 16'h01FF);
    do_op(cvr_op_aux_inc, 0);
    do_op(cvr_op_data_pointer_load, 16'h02FF);
    repeat (3) do_op(cvr_op_aux_inc, 0);
    do_wr(8'h82, 8'hFF);
    do_wr(8'h83, 8'hFF);
    do_op(cvr_op_data_pointer_inc, 0);
    do_rd(8'h82);
    do_rd(8'h83);
    do_wr(8'hA2, 8'hFF);
    do_rd(8'hA2);
    do_op(cvr_op_aux_inc, 0);
    do_rd(8'hA2);
    // command dropped when a register write shares the cycle
    step({1'b1, cvr_op_push, 16'h0000}, {1'b1, 1'b0, 8'hE0, 8'h5A});
    // random mix of commands and register traffic
    for (i = 0; i < 300; i++) begin
      k = $unsigned($random(seed)) % 12;
      if (k == 4 || k == 5) k = 1;
      c = {1'($random(seed)), cvr_op_t'(k), 16'($random(seed))};
      r = $random(seed);
      s = {1'(r[0] & r[1]), 1'(~(r[0] & r[1]) & r[2]), addrs[$unsigned(r) % 9], 8'(r >> 8)};
      step(c, s);
    end
    // second reset in mid-run
    cmd = '0;
    sfr = '0;
    srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    m_reset();
    check_all();
    do_rd(8'hA2);
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
